// >>> lpm_regs.vh
// Purpose: Offsets, field positions, reset values and timing counts of the power-mode controller.
// Assumes: Included by the controller files only.
// Notes: Byte addresses on the AHB-Lite register bus.
`ifndef LPM_REGS_VH
`define LPM_REGS_VH
`define LPM_PLL_CONTROL_OFFSET   8'h00
`define LPM_STATUS_OFFSET        8'h04
`define LPM_POWER_DOWN_ALL_BIT   0
`define LPM_CORE_CLOCK_STOP_BIT  1
`define LPM_CORE_PERIPH_STOP_BIT 2
`define LPM_PERIPH_DIV_SEL_BIT   3
`define LPM_PLL_CONTROL_RESET    4'h0
`define LPM_IDLE_WAKE_CYCLES     16'd2
`define LPM_CORE_WAKE_CYCLES     16'd2
`define LPM_CPER_WAKE_CYCLES     16'd5
`define LPM_PLL_RELOCK_CYCLES    500
`define LPM_MODE_RUN             3'h0
`define LPM_MODE_IDLE            3'h1
`define LPM_MODE_CORE            3'h2
`define LPM_MODE_CPER            3'h3
`define LPM_MODE_ALL             3'h4
`define LPM_MODE_WAKE            3'h5
`endif

// >>> periph_clock_divider.v
// Purpose: Peripheral clock enable at the core rate or at half of it.
// Assumes: One system clock; the enable qualifies peripheral logic.
// Notes: The enable is gated by run_in here; the caller drives run_in.
`timescale 1ns/1ps
module periph_clock_divider (
    input  wire sys_clk_in,
    input  wire rst_in,
    input  wire half_rate_in,
    input  wire run_in,
    output wire periph_tick_out
);
    reg phase_q;
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            phase_q <= 1'b0;
        end else if (run_in) begin
            phase_q <= ~phase_q;
        end
    end
    assign periph_tick_out = run_in & (~half_rate_in | phase_q);
endmodule // periph_clock_divider

// >>> wake_counter.v
// Purpose: Counts down a wake latency and flags its end.
// Assumes: Load and count are exclusive in use.
// Notes: The width covers the relock count.
`timescale 1ns/1ps
module wake_counter #(
    parameter WIDTH = 16
) (
    input  wire             sys_clk_in,
    input  wire             rst_in,
    input  wire             load_in,
    input  wire [WIDTH-1:0] load_value_in,
    output wire             done_out
);
    reg [WIDTH-1:0] count_q;
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            count_q <= {WIDTH{1'b0}};
        end else if (load_in) begin
            count_q <= load_value_in;
        end else if (count_q != {WIDTH{1'b0}}) begin
            count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
    assign done_out = (count_q == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule // wake_counter

// >>> low_power_mode_controller.v
// Purpose: Chooses and sequences the four standby modes on a halt instruction.
// Assumes: Halt and interrupt inputs are single-cycle pulses synchronous to sys_clk_in.
// Notes: Clock gating is expressed as run enables; the core sequencer applies them.
`timescale 1ns/1ps
`include "lpm_regs.vh"
// Contract
// - Low-power mode is entered only on a halt; stop bits choose the mode.
// - Plain idle: core stops, pipeline kept, both clocks keep running.
// - Idle wake: resume after two cycles at the instruction after halt.
// - Core power-down: core clock off, PLL and peripheral bus running, pipeline kept.
// - Core power-down chosen when all-bit 0, periph-stop 0, clock-stop 1.
// - Core power-down wake: restart core clock, resume after two cycles.
// - Core/peripheral power-down: both clocks off, PLL on, pipeline lost.
// - Core/peripheral power-down chosen when all-bit 0 and periph-stop 1.
// - Core/peripheral wake: restart clocks, resume after five to six cycles.
// - Full power-down: core, peripheral clock and PLL stopped, pipeline lost.
// - Full power-down chosen whenever the all-bit is 1.
// - Full power-down wake: restart PLL, wait 500 cycles, then resume.
// - Peripheral clock runs at core rate or half, by divide select.
module low_power_mode_controller #(
    parameter PLL_RELOCK_CYCLES = `LPM_PLL_RELOCK_CYCLES
) (
    input  wire        sys_clk_in,
    input  wire        rst_in,
    input  wire [31:0] haddr_in,
    input  wire [1:0]  htrans_in,
    input  wire        hwrite_in,
    input  wire [2:0]  hsize_in,
    input  wire        hsel_in,
    input  wire        hready_in,
    input  wire [31:0] hwdata_in,
    output wire [31:0] hrdata_out,
    output wire        hreadyout_out,
    output wire        hresp_out,
    input  wire        halt_exec_in,
    input  wire        interrupt_in,
    output wire        core_clock_run_out,
    output wire        periph_clock_run_out,
    output wire        periph_tick_out,
    output wire        pll_run_out,
    output wire        pipeline_keep_out,
    output wire        pipeline_flush_out,
    output wire        core_resume_out,
    output wire        standby_out
);
    // The relock count is cut to the counter width on purpose.
    localparam [31:0] RELOCK_FULL = PLL_RELOCK_CYCLES;
    localparam [15:0] RELOCK      = RELOCK_FULL[15:0];

    reg  [3:0]  pll_control_register_q;
    reg  [2:0]  mode_q;
    reg  [2:0]  mode_d;
    reg  [2:0]  last_mode_q;
    reg  [2:0]  last_mode_d;
    reg         flush_q;
    reg         flush_d;
    reg         resume_q;
    reg         resume_d;
    reg         load_d;
    reg  [15:0] load_value_d;
    reg  [31:0] hrdata_q;
    reg         wr_pend_q;
    reg  [7:0]  wr_addr_q;
    wire        wake_done;
    wire        bus_take;

    wire power_down_all_bit   = pll_control_register_q[`LPM_POWER_DOWN_ALL_BIT];
    wire core_clock_stop_bit  = pll_control_register_q[`LPM_CORE_CLOCK_STOP_BIT];
    wire core_periph_stop_bit = pll_control_register_q[`LPM_CORE_PERIPH_STOP_BIT];
    wire periph_clock_divide_select = pll_control_register_q[`LPM_PERIPH_DIV_SEL_BIT];

    // Mode chosen from the stop bits; the all-bit dominates the others.
    function [2:0] select_mode;
        input all_bit;
        input cper_bit;
        input core_bit;
        begin
            if (all_bit) begin
                select_mode = `LPM_MODE_ALL;
            end else if (cper_bit) begin
                select_mode = `LPM_MODE_CPER;
            end else if (core_bit) begin
                select_mode = `LPM_MODE_CORE;
            end else begin
                select_mode = `LPM_MODE_IDLE;
            end
        end
    endfunction

    // Single-cycle zero-wait AHB-Lite slave; writes land in the data phase.
    assign bus_take = hsel_in & hready_in & htrans_in[1];
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            pll_control_register_q <= `LPM_PLL_CONTROL_RESET;
            wr_pend_q              <= 1'b0;
            wr_addr_q              <= 8'h00;
            hrdata_q               <= 32'h00000000;
        end else begin
            wr_pend_q <= bus_take & hwrite_in;
            wr_addr_q <= haddr_in[7:0];
            if (wr_pend_q && wr_addr_q == `LPM_PLL_CONTROL_OFFSET) begin
                pll_control_register_q <= hwdata_in[3:0];
            end
            if (bus_take && !hwrite_in) begin
                case (haddr_in[7:0])
                    `LPM_PLL_CONTROL_OFFSET: hrdata_q <= {28'h0000000, pll_control_register_q};
                    `LPM_STATUS_OFFSET:      hrdata_q <= {29'h0000000, mode_q};
                    default:                 hrdata_q <= 32'h00000000;
                endcase
            end
        end
    end
    assign hrdata_out    = hrdata_q;
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;

    // Mode sequencer.
    always @* begin
        mode_d       = mode_q;
        last_mode_d  = last_mode_q;
        flush_d      = 1'b0;
        resume_d     = 1'b0;
        load_d       = 1'b0;
        load_value_d = 16'h0000;
        case (mode_q)
            `LPM_MODE_RUN: begin
                if (halt_exec_in) begin
                    mode_d      = select_mode(power_down_all_bit, core_periph_stop_bit, core_clock_stop_bit);
                    last_mode_d = mode_d;
                end
            end
            `LPM_MODE_IDLE, `LPM_MODE_CORE: begin
                if (interrupt_in) begin
                    mode_d       = `LPM_MODE_WAKE;
                    load_d       = 1'b1;
                    load_value_d = (mode_q == `LPM_MODE_IDLE) ? `LPM_IDLE_WAKE_CYCLES
                                                              : `LPM_CORE_WAKE_CYCLES;
                end
            end
            `LPM_MODE_CPER: begin
                if (interrupt_in) begin
                    mode_d       = `LPM_MODE_WAKE;
                    load_d       = 1'b1;
                    load_value_d = `LPM_CPER_WAKE_CYCLES;
                    flush_d      = 1'b1;
                end
            end
            `LPM_MODE_ALL: begin
                if (interrupt_in) begin
                    mode_d       = `LPM_MODE_WAKE;
                    load_d       = 1'b1;
                    load_value_d = RELOCK;
                    flush_d      = 1'b1;
                end
            end
            `LPM_MODE_WAKE: begin
                if (wake_done) begin
                    mode_d   = `LPM_MODE_RUN;
                    resume_d = 1'b1;
                end
            end
            default: begin
                mode_d = `LPM_MODE_RUN;
            end
        endcase
    end

    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            mode_q      <= `LPM_MODE_RUN;
            last_mode_q <= `LPM_MODE_RUN;
            flush_q     <= 1'b0;
            resume_q    <= 1'b0;
        end else begin
            mode_q      <= mode_d;
            last_mode_q <= last_mode_d;
            flush_q     <= flush_d;
            resume_q    <= resume_d;
        end
    end

    wake_counter #(
        .WIDTH(16)
    ) u_wake_counter (
        .sys_clk_in   (sys_clk_in),
        .rst_in       (rst_in),
        .load_in      (load_d),
        .load_value_in(load_value_d),
        .done_out     (wake_done)
    );

    // Clocks restart at wake so the core sees them before it resumes.
    assign core_clock_run_out   = (mode_q == `LPM_MODE_RUN) || (mode_q == `LPM_MODE_IDLE)
                                  || (mode_q == `LPM_MODE_WAKE);
    assign periph_clock_run_out = (mode_q != `LPM_MODE_CPER) && (mode_q != `LPM_MODE_ALL);
    assign pll_run_out          = (mode_q != `LPM_MODE_ALL);
    assign pipeline_keep_out    = (mode_q == `LPM_MODE_IDLE) || (mode_q == `LPM_MODE_CORE)
                                  || ((mode_q == `LPM_MODE_WAKE) && (last_mode_q != `LPM_MODE_CPER)
                                      && (last_mode_q != `LPM_MODE_ALL));
    assign pipeline_flush_out   = flush_q;
    assign core_resume_out      = resume_q;
    assign standby_out          = (mode_q != `LPM_MODE_RUN);

    periph_clock_divider u_periph_clock_divider (
        .sys_clk_in     (sys_clk_in),
        .rst_in         (rst_in),
        .half_rate_in   (periph_clock_divide_select),
        .run_in         (periph_clock_run_out),
        .periph_tick_out(periph_tick_out)
    );
endmodule // low_power_mode_controller

// >>> lpm_properties.sv
// Purpose: Concurrent checks on the power-mode controller ports.
// Assumes: Software writes the control word at offset zero only.
// Notes: The standby mode is inferred from the run outputs.
`timescale 1ns/1ps
module lpm_checker #(parameter PLL_RELOCK_CYCLES = 500) (
    input wire logic        sys_clk_in,
    input wire logic        rst_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic        hsel_in,
    input wire logic        hready_in,
    input wire logic [31:0] hwdata_in,
    input wire logic        halt_exec_in,
    input wire logic        interrupt_in,
    input wire logic        core_clock_run_out,
    input wire logic        periph_clock_run_out,
    input wire logic        periph_tick_out,
    input wire logic        pll_run_out,
    input wire logic        pipeline_keep_out,
    input wire logic        pipeline_flush_out,
    input wire logic        core_resume_out,
    input wire logic        standby_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    logic       ph_q;
    logic [3:0] ctrl_q;
    logic [15:0] cnt_q;
    wire go_w = halt_exec_in & !standby_out;
    wire wk_w = interrupt_in & standby_out;
    // Shadow of the control word, so mode choice can be tied to the bits.
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            ph_q <= 1'b0;
            ctrl_q <= 4'h0;
            cnt_q <= 16'h0;
        end else begin
            ph_q <= hsel_in & hready_in & htrans_in[1] & hwrite_in & (haddr_in[7:0] == 8'h00);
            if (ph_q) ctrl_q <= hwdata_in[3:0];
            if (wk_w & !pll_run_out) cnt_q <= 16'h1;
            else if (core_resume_out) cnt_q <= 16'h0;
            else if (cnt_q != 16'h0) cnt_q <= cnt_q + 16'h1;
        end
    end
    entry_on_halt_a: assert property ($rose(standby_out) |-> $past(halt_exec_in))
        else $error("standby entered without halt");
    idle_select_a: assert property (go_w && ctrl_q[2:0] == 3'h0 |=> standby_out && core_clock_run_out &&
        periph_clock_run_out && pll_run_out && pipeline_keep_out) else $error("idle mode wrong");
    core_select_a: assert property (go_w && ctrl_q[2:0] == 3'h2 |=> !core_clock_run_out &&
        periph_clock_run_out && pll_run_out && pipeline_keep_out) else $error("core mode wrong");
    cper_select_a: assert property (go_w && ctrl_q[2:0] inside {3'h4, 3'h6} |=>
        !core_clock_run_out && !periph_clock_run_out && pll_run_out && !pipeline_keep_out)
        else $error("core periph mode wrong");
    all_select_a: assert property (go_w && ctrl_q[0] |=> !core_clock_run_out &&
        !periph_clock_run_out && !pll_run_out && !pipeline_keep_out) else $error("all mode wrong");
    fast_wake_a: assert property (wk_w && pipeline_keep_out |=> !core_resume_out ##1 !core_resume_out ##1 core_resume_out)
        else $error("fast wake latency wrong");
    cper_wake_a: assert property (wk_w && pll_run_out && !periph_clock_run_out |=>
        !core_resume_out[*5] ##1 core_resume_out) else $error("core periph wake latency wrong");
    relock_wait_a: assert property (core_resume_out && cnt_q != 16'h0 |-> cnt_q == PLL_RELOCK_CYCLES + 1)
        else $error("relock wait wrong");
    flush_pulse_a: assert property (wk_w && !periph_clock_run_out |=> pipeline_flush_out ##1 !pipeline_flush_out)
        else $error("pipeline flush pulse wrong");
    tick_stopped_a: assert property (!periph_clock_run_out |-> !periph_tick_out)
        else $error("tick while stopped");
    tick_half_a: assert property (periph_tick_out && ctrl_q[3] ##1 ctrl_q[3] |-> !periph_tick_out)
        else $error("half rate tick wrong");
    tick_full_a: assert property ((periph_clock_run_out && !ctrl_q[3])[*2] |-> periph_tick_out)
        else $error("full rate tick missing");
    cover property (go_w && ctrl_q[0]);
    cover property (wk_w && !periph_clock_run_out);
    cover property (go_w && ctrl_q[2:0] == 3'h2);
endmodule // lpm_checker
bind low_power_mode_controller lpm_checker #(.PLL_RELOCK_CYCLES(PLL_RELOCK_CYCLES)) chk (.*);

// >>> dsp_core_model.sv
// Purpose: Core sequencer model issuing halt and wake pulses.
// Assumes: Requests from the bench last one cycle.
// Notes: Measures cycles from its interrupt to the resume pulse.
`timescale 1ns/1ps
module dsp_core_model (
    input  wire logic        sys_clk_in,
    input  wire logic        halt_req_in,
    input  wire logic        irq_req_in,
    input  wire logic        standby_in,
    input  wire logic        core_resume_in,
    output logic             halt_exec_out = 1'b0,
    output logic             interrupt_out = 1'b0,
    output logic [15:0]      wake_cycles_out = 16'h0
);
    logic cnt_q = 1'b0;
    // A real core never halts while halted nor takes a wake while running.
    always @(posedge sys_clk_in) begin
        halt_exec_out <= halt_req_in & !standby_in;
        interrupt_out <= irq_req_in & standby_in;
        if (interrupt_out) begin
            wake_cycles_out <= 16'h0;
            cnt_q <= 1'b1;
        end else if (cnt_q & core_resume_in) cnt_q <= 1'b0;
        else if (cnt_q) wake_cycles_out <= wake_cycles_out + 16'h1;
    end
endmodule // dsp_core_model

// >>> low_power_mode_controller_bench.sv
// Purpose: Walks every control setting through halt and wake.
// Assumes: Relock count shortened to keep the run brief.
// Notes: Expected modes and latencies derive from the control bits.
`timescale 1ns/1ps
module low_power_mode_controller_bench;
    localparam int RELOCK = 8;
    logic sys_clk_in = 1'b0, rst_in = 1'b1, hwrite = 1'b0, halt_req = 1'b0, irq_req = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    wire [31:0] hrdata;
    wire [15:0] wake;
    wire hready, core_run, per_run, tick, pll, keep, resume, stby, halt, irq;
    logic [4:0] exp_o [1:4] = '{5'h1f, 5'h0f, 5'h05, 5'h01};
    int n_errors = 0, cmp_count = 0, m, lat;
    always #4 sys_clk_in = ~sys_clk_in;
    low_power_mode_controller #(.PLL_RELOCK_CYCLES(RELOCK)) dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hsel_in(1'b1),
        .hready_in(hready), .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(),
        .halt_exec_in(halt), .interrupt_in(irq), .core_clock_run_out(core_run), .periph_clock_run_out(per_run),
        .periph_tick_out(tick), .pll_run_out(pll), .pipeline_keep_out(keep), .pipeline_flush_out(),
        .core_resume_out(resume), .standby_out(stby));
    dsp_core_model core (.sys_clk_in(sys_clk_in), .halt_req_in(halt_req), .irq_req_in(irq_req),
        .standby_in(stby), .core_resume_in(resume), .halt_exec_out(halt), .interrupt_out(irq),
        .wake_cycles_out(wake));
    task final_report;
        if (n_errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge sys_clk_in);
        while (hready !== 1'b1) @(posedge sys_clk_in);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge sys_clk_in);
        while (hready !== 1'b1) @(posedge sys_clk_in);
        rd = hrdata;
    endtask
    initial begin
        repeat (10) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        @(posedge sys_clk_in);
        ahb(1'b0, 8'h08, 32'h0); chk(rd, 32'h0);
        ahb(1'b0, 8'h04, 32'h0); chk(rd, 32'h0);
        for (int c = 0; c < 16; c++) begin
            m = c[0] ? 4 : c[2] ? 3 : c[1] ? 2 : 1;
            lat = m == 4 ? RELOCK : m == 3 ? 5 : 2;
            ahb(1'b1, 8'h00, c);
            ahb(1'b0, 8'h00, 32'h0); chk(rd, c);
            halt_req <= 1'b1;
            @(posedge sys_clk_in);
            halt_req <= 1'b0;
            repeat (2) @(posedge sys_clk_in);
            ahb(1'b0, 8'h04, 32'h0); chk(rd, m);
            chk({core_run, per_run, pll, keep, stby}, exp_o[m]);
            if (m > 2) chk(tick, 1'b0);
            irq_req <= 1'b1;
            @(posedge sys_clk_in);
            irq_req <= 1'b0;
            for (int k = 0; k < 600 && resume !== 1'b1; k++) @(posedge sys_clk_in);
            @(posedge sys_clk_in);
            chk(wake, lat);
            chk(stby, 1'b0);
        end
        final_report;
    end
    // Whole sequence needs well under a thousand cycles.
    initial begin
        #100000;
        n_errors++;
        final_report;
    end
endmodule // low_power_mode_controller_bench
